// ---- rtl/cdp_consts.svh ----
// offsets, field positions, reset values and timing counts of the codec digital port
`ifndef CDP_CONSTS_SVH
`define CDP_CONSTS_SVH

`define CDP_OFS_CTRL      5'h00
`define CDP_OFS_STATUS    5'h04
`define CDP_OFS_MASK      5'h08
`define CDP_OFS_TXDATA    5'h0c
`define CDP_OFS_RXDATA    5'h10
`define CDP_OFS_LEVEL     5'h14
`define CDP_OFS_DCHAN     5'h18

`define CDP_ST_RX_DONE    0
`define CDP_ST_TX_DONE    1
`define CDP_ST_DCH_ACC    2
`define CDP_ST_MP_WRITE   3

`define CDP_CTRL_RST      9'h000
`define CDP_BYTE_RST      8'h00
`define CDP_SLOT_BITS     8
`define CDP_CASCADE_SLOTS 4
`define CDP_CASCADE_BIT   (`CDP_SLOT_BITS * `CDP_CASCADE_SLOTS)
`define CDP_BITPOS_MAX    10'h3ff

`endif

// ---- rtl/cdp_pkg.sv ----
// types shared by the codec digital port design
package cdp_pkg;

   typedef struct packed {
      logic [4:0] chan;
      logic       split_wire;
      logic       frame_bus_mode;
      logic       d_channel_enable_bit;
      logic       law_a;
   } cdp_ctrl_t;

   typedef enum logic [1:0] {
      MP_IDLE,
      MP_CMD,
      MP_DATA
   } cdp_mp_state_t;

   typedef struct packed {
      cdp_ctrl_t     ctrl;
      logic [3:0]    status;
      logic [3:0]    mask;
      logic [7:0]    tx_data;
      logic [7:0]    rx_data;
      logic [7:0]    dchan;
      logic          waitreq;
      logic [31:0]   rdata;
      logic          irq;
      logic          bclk_q;
      logic          strb_prev;
      logic [9:0]    bitpos;
      logic          slot_act;
      logic [3:0]    dly_cnt;
      logic          dly_out;
      logic          dout;
      logic          dout_oe_n;
      logic          law_o_oe_n;
      logic          a_law;
      logic          sclk_q;
      cdp_mp_state_t mp_st;
      logic [3:0]    mp_cnt;
      logic          mp_rd;
      logic [4:0]    mp_ofs;
      logic          d1_out;
      logic          d1_oe_n;
   } cdp_core_t;

endpackage

// ---- rtl/cdp_sync.sv ----
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module cdp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // pins and synchronised copy
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   always_comb begin
      meta_nxt = d;
      q_nxt    = meta_r;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= meta_nxt;
         q_r    <= q_nxt;
      end
   end

   assign q = q_r;
endmodule

// ---- rtl/cdp_shreg.sv ----
// loadable shift register, msb first
`timescale 1ns/100ps
module cdp_shreg #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic         shift,
   input  wire logic         sin,
   // contents
   output logic      [W-1:0] q
);
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   always_comb begin
      q_nxt = q_r;
      if (load) begin
         q_nxt = load_val;
      end else if (shift) begin
         q_nxt = {q_r[W-2:0], sin};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule

// ---- rtl/cdp_port.sv ----
// codec digital port: channel serial port, control microport, law/interrupt pin
`timescale 1ns/100ps
`include "cdp_consts.svh"
module cdp_port (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // avalon-mm slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   output logic             irq,
   // power-on clear pin
   input  wire logic        power_on_clear_n,
   // channel serial port
   input  wire logic        bit_clk,
   input  wire logic        slot_strobe,
   input  wire logic        chan_din,
   output logic             chan_dout,
   output logic             chan_dout_oe_n,
   output logic             delayed_strobe_out,
   // control microport
   input  wire logic        mp_cs_n,
   input  wire logic        mp_sclk,
   input  wire logic        mp_data1_i,
   output logic             mp_data1_o,
   output logic             mp_data1_oe_n,
   input  wire logic        mp_data2,
   // law select / interrupt pin and effective law
   input  wire logic        law_pin_i,
   output logic             law_pin_o,
   output logic             law_pin_oe_n,
   output logic             a_law_sel
);
   cdp_pkg::cdp_core_t s_r;
   cdp_pkg::cdp_core_t s_nxt;
   cdp_pkg::cdp_core_t s_rst;

   logic [8:0] pins;
   logic       poc_n_s;
   logic       bclk_s;
   logic       strb_s;
   logic       din_s;
   logic       cs_n_s;
   logic       sclk_s;
   logic       d1_s;
   logic       d2_s;
   logic       law_s;

   // every pin is off this clock's domain
   cdp_sync #(.W(9)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({power_on_clear_n, bit_clk, slot_strobe, chan_din, mp_cs_n, mp_sclk,
             mp_data1_i, mp_data2, law_pin_i}),
      .q   (pins)
   );
   assign {poc_n_s, bclk_s, strb_s, din_s, cs_n_s, sclk_s, d1_s, d2_s, law_s} = pins;

   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic [7:0] mp_q;
   logic       tx_load;
   logic       rx_shift;
   logic       mp_load;
   logic [7:0] mp_load_val;
   logic       mp_shift;
   logic       mp_sin;

   cdp_shreg #(.W(8)) u_tx (
      .clk      (clk),
      .rst      (rst),
      .load     (tx_load),
      .load_val ({s_r.tx_data[6:0], 1'b0}),
      .shift    (s_nxt.slot_act & bclk_s & ~s_r.bclk_q & ~tx_load),
      .sin      (1'b0),
      .q        (tx_q)
   );

   cdp_shreg #(.W(8)) u_rx (
      .clk      (clk),
      .rst      (rst),
      .load     (1'b0),
      .load_val (8'h00),
      .shift    (rx_shift),
      .sin      (din_s),
      .q        (rx_q)
   );

   cdp_shreg #(.W(8)) u_mp (
      .clk      (clk),
      .rst      (rst),
      .load     (mp_load),
      .load_val (mp_load_val),
      .shift    (mp_shift),
      .sin      (mp_sin),
      .q        (mp_q)
   );

   // register read view shared by the bus and the microport
   function automatic logic [31:0] rd_val(cdp_pkg::cdp_core_t s, logic [4:0] ofs, logic lvl);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (ofs)
         `CDP_OFS_CTRL:   v = {23'h000000, s.ctrl};
         `CDP_OFS_STATUS: v = {28'h0000000, s.status};
         `CDP_OFS_MASK:   v = {28'h0000000, s.mask};
         `CDP_OFS_TXDATA: v = {24'h000000, s.tx_data};
         `CDP_OFS_RXDATA: v = {24'h000000, s.rx_data};
         `CDP_OFS_LEVEL:  v = {29'h00000000, lvl, s.a_law, s.irq};
         `CDP_OFS_DCHAN:  v = {24'h000000, s.dchan};
         default:         v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // register write; status bits clear on writing one
   function automatic cdp_pkg::cdp_core_t wr_reg(cdp_pkg::cdp_core_t s, logic [4:0] ofs,
                                                 logic [31:0] d);
      cdp_pkg::cdp_core_t t;
      t = s;
      case (ofs)
         `CDP_OFS_CTRL:   t.ctrl    = cdp_pkg::cdp_ctrl_t'(d[8:0]);
         `CDP_OFS_STATUS: t.status  = s.status & ~d[3:0];
         `CDP_OFS_MASK:   t.mask    = d[3:0];
         `CDP_OFS_TXDATA: t.tx_data = d[7:0];
         `CDP_OFS_DCHAN:  t.dchan   = d[7:0];
         default:         t = s;
      endcase
      return t;
   endfunction

   always_comb begin
      s_rst            = '0;
      s_rst.ctrl       = cdp_pkg::cdp_ctrl_t'(`CDP_CTRL_RST);
      s_rst.tx_data    = `CDP_BYTE_RST;
      s_rst.rx_data    = `CDP_BYTE_RST;
      s_rst.dchan      = `CDP_BYTE_RST;
      s_rst.waitreq    = 1'b1;
      s_rst.dout_oe_n  = 1'b1;
      s_rst.law_o_oe_n = 1'b1;
      s_rst.d1_oe_n    = 1'b1;
      s_rst.mp_st      = cdp_pkg::MP_IDLE;
   end

   logic        b_rise;
   logic        b_fall;
   logic        sc_rise;
   logic        sc_fall;
   logic        frame_start;
   logic        strb_fall;
   logic [9:0]  nbitpos;
   logic        mp_wr_go;
   logic [7:0]  mp_byte;
   logic [3:0]  ev;
   logic [31:0] mp_rd_word;

   always_comb begin
      s_nxt       = s_r;
      b_rise      = bclk_s & ~s_r.bclk_q;
      b_fall      = ~bclk_s & s_r.bclk_q;
      sc_rise     = sclk_s & ~s_r.sclk_q;
      sc_fall     = ~sclk_s & s_r.sclk_q;
      tx_load     = 1'b0;
      rx_shift    = 1'b0;
      mp_load     = 1'b0;
      mp_load_val = 8'h00;
      mp_shift    = 1'b0;
      mp_wr_go    = 1'b0;
      ev          = 4'h0;
      // single-wire mode listens on data1 only; split-wire on data2
      mp_sin      = s_r.ctrl.split_wire ? d2_s : d1_s;
      mp_byte     = {mp_q[6:0], mp_sin};
      mp_rd_word  = rd_val(s_r, {mp_byte[2:0], 2'b00}, law_s);
      s_nxt.bclk_q = bclk_s;
      s_nxt.sclk_q = sclk_s;

      // strobed mode starts on strobe rise, frame-pulse mode on low pulse
      frame_start = s_r.ctrl.frame_bus_mode ? ~strb_s : (strb_s & ~s_r.strb_prev);
      strb_fall   = ~strb_s & s_r.strb_prev;
      nbitpos     = frame_start ? 10'h000 :
                    (s_r.bitpos == `CDP_BITPOS_MAX) ? s_r.bitpos : s_r.bitpos + 10'h001;

      // channel port, transmit side on the bit clock rising edge
      if (b_rise) begin
         s_nxt.strb_prev = strb_s;
         s_nxt.bitpos    = nbitpos;
         s_nxt.slot_act  = s_r.ctrl.frame_bus_mode ?
                           (nbitpos[9:3] == {2'b00, s_r.ctrl.chan}) : strb_s;
         s_nxt.dout_oe_n = ~s_nxt.slot_act;
         if (s_nxt.slot_act) begin
            if (nbitpos[2:0] == 3'h0) begin
               tx_load    = 1'b1;
               s_nxt.dout = s_r.tx_data[7];
            end else begin
               s_nxt.dout = tx_q[7];
            end
            if (nbitpos[2:0] == 3'h7) begin
               ev[`CDP_ST_TX_DONE] = 1'b1;
            end
         end
         // cascade output for chained devices
         if (s_r.ctrl.frame_bus_mode) begin
            s_nxt.dly_cnt = 4'h0;
            s_nxt.dly_out = ~(nbitpos == 10'(`CDP_CASCADE_BIT));
         end else begin
            if (strb_fall) begin
               s_nxt.dly_cnt = 4'(`CDP_SLOT_BITS);
            end else if (s_r.dly_cnt != 4'h0) begin
               s_nxt.dly_cnt = s_r.dly_cnt - 4'h1;
            end
            s_nxt.dly_out = (s_nxt.dly_cnt != 4'h0);
         end
      end

      // channel port, receive side on the falling edge
      if (b_fall && s_r.slot_act) begin
         rx_shift = 1'b1;
         if (s_r.bitpos[2:0] == 3'h7) begin
            s_nxt.rx_data       = {rx_q[6:0], din_s};
            ev[`CDP_ST_RX_DONE] = 1'b1;
         end
      end

      // control microport; chip select frames every transfer
      if (cs_n_s) begin
         s_nxt.mp_st   = cdp_pkg::MP_IDLE;
         s_nxt.mp_cnt  = 4'h0;
         s_nxt.d1_oe_n = 1'b1;
      end else begin
         case (s_r.mp_st)
            cdp_pkg::MP_IDLE: begin
               s_nxt.mp_st  = cdp_pkg::MP_CMD;
               s_nxt.mp_cnt = 4'h0;
            end
            cdp_pkg::MP_CMD: begin
               if (sc_rise) begin
                  mp_shift     = 1'b1;
                  s_nxt.mp_cnt = s_r.mp_cnt + 4'h1;
                  if (s_r.mp_cnt == 4'h7) begin
                     s_nxt.mp_rd  = mp_byte[7];
                     s_nxt.mp_ofs = {mp_byte[2:0], 2'b00};
                     s_nxt.mp_st  = cdp_pkg::MP_DATA;
                     s_nxt.mp_cnt = 4'h0;
                     if (mp_byte[7]) begin
                        mp_shift    = 1'b0;
                        mp_load     = 1'b1;
                        mp_load_val = mp_rd_word[7:0];
                     end
                     if ({mp_byte[2:0], 2'b00} == `CDP_OFS_DCHAN &&
                         s_r.ctrl.frame_bus_mode) begin
                        ev[`CDP_ST_DCH_ACC] = 1'b1;
                     end
                  end
               end
            end
            cdp_pkg::MP_DATA: begin
               if (s_r.mp_rd) begin
                  // both wire modes answer on data1
                  if (sc_fall && s_r.mp_cnt != 4'h8) begin
                     mp_shift      = 1'b1;
                     s_nxt.d1_out  = mp_q[7];
                     s_nxt.d1_oe_n = 1'b0;
                     s_nxt.mp_cnt  = s_r.mp_cnt + 4'h1;
                  end
               end else if (sc_rise && s_r.mp_cnt != 4'h8) begin
                  mp_shift     = 1'b1;
                  s_nxt.mp_cnt = s_r.mp_cnt + 4'h1;
                  if (s_r.mp_cnt == 4'h7) begin
                     mp_wr_go             = 1'b1;
                     ev[`CDP_ST_MP_WRITE] = 1'b1;
                  end
               end
            end
            default: begin
               s_nxt.mp_st = cdp_pkg::MP_IDLE;
            end
         endcase
      end
      if (mp_wr_go) begin
         s_nxt = wr_reg(s_nxt, s_r.mp_ofs, {24'h000000, mp_byte});
      end

      // avalon slave: one wait cycle, then the access completes
      s_nxt.waitreq = ~((read | write) & s_r.waitreq);
      if ((read | write) && s_r.waitreq) begin
         s_nxt.rdata = read ? rd_val(s_r, {address[4:2], 2'b00}, law_s) : 32'h0000_0000;
      end
      if (write && !s_r.waitreq) begin
         s_nxt = wr_reg(s_nxt, {address[4:2], 2'b00}, writedata);
      end

      // events win over a clear in the same cycle
      s_nxt.status = s_nxt.status | ev;
      s_nxt.irq    = |(s_nxt.status & s_nxt.mask);

      // law pin: input, or open-drain interrupt pulled low while access pending
      if (s_nxt.ctrl.d_channel_enable_bit) begin
         s_nxt.law_o_oe_n = ~s_nxt.status[`CDP_ST_DCH_ACC];
         s_nxt.a_law      = s_nxt.ctrl.law_a;
      end else begin
         s_nxt.law_o_oe_n = 1'b1;
         s_nxt.a_law      = law_s | s_nxt.ctrl.law_a;
      end

      // defaults alone run the port, no microport traffic needed
      if (!poc_n_s) begin
         s_nxt = s_rst;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.waitreq    <= 1'b1;
         s_r.dout_oe_n  <= 1'b1;
         s_r.law_o_oe_n <= 1'b1;
         s_r.d1_oe_n    <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign readdata           = s_r.rdata;
   assign waitrequest        = s_r.waitreq;
   assign irq                = s_r.irq;
   assign chan_dout          = s_r.dout;
   assign chan_dout_oe_n     = s_r.dout_oe_n;
   assign delayed_strobe_out = s_r.dly_out;
   assign mp_data1_o         = s_r.d1_out;
   assign mp_data1_oe_n      = s_r.d1_oe_n;
   assign law_pin_o          = 1'b0;
   assign law_pin_oe_n       = s_r.law_o_oe_n;
   assign a_law_sel          = s_r.a_law;
endmodule

// ---- verif/cdp_port_asserts.sv ----
// concurrent checks on the codec digital port pins
`timescale 1ns/100ps
module cdp_port_asserts (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // register bus
   input wire logic [4:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // pins
   input wire logic        bit_clk,
   input wire logic        chan_dout,
   input wire logic        chan_dout_oe_n,
   input wire logic        delayed_strobe_out,
   input wire logic        mp_cs_n,
   input wire logic        mp_data1_oe_n,
   input wire logic        law_pin_i,
   input wire logic        law_pin_o,
   input wire logic        a_law_sel
);
   logic [7:0] slot_cnt_r;
   logic [7:0] hi_cnt_r;
   logic [7:0] lo_cnt_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // run lengths, the two strobe ones saturating; long strobe runs are skipped below
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_cnt_r <= 8'h00;
         hi_cnt_r <= 8'h00;
         lo_cnt_r <= 8'h00;
      end else begin
         slot_cnt_r <= chan_dout_oe_n ? 8'h00 : slot_cnt_r + 8'h01;
         hi_cnt_r <= !delayed_strobe_out ? 8'h00 : hi_cnt_r + 8'(hi_cnt_r != 8'hff);
         lo_cnt_r <= delayed_strobe_out ? 8'h00 : lo_cnt_r + 8'(lo_cnt_r != 8'hff);
      end
   end
   property p_wait_ans;
      (read || write) && waitrequest |=> !waitrequest;
   endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("no answer one cycle after request");
   property p_wait_one;
      !waitrequest |=> waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low two cycles");
   property p_unmapped;
      read && !waitrequest && address[4:2] == 3'h7 |-> readdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_law_o;
      law_pin_o == 1'b0;
   endproperty
   a_law_o: assert property (p_law_o) else $error("law pin drives high");
   property p_law_a;
      law_pin_i [*6] |=> a_law_sel;
   endproperty
   a_law_a: assert property (p_law_a) else $error("high law pin not giving a-law");
   property p_dout_edge;
      $changed(chan_dout) && !chan_dout_oe_n |-> bit_clk && $past(bit_clk, 2);
   endproperty
   a_dout_edge: assert property (p_dout_edge) else $error("data out moved off rise");
   property p_oe_edge;
      $changed(chan_dout_oe_n) |-> bit_clk && $past(bit_clk, 2);
   endproperty
   a_oe_edge: assert property (p_oe_edge) else $error("output enable moved off rise");
   property p_slot_len;
      $rose(chan_dout_oe_n) |-> slot_cnt_r >= 8'd98 && slot_cnt_r <= 8'd102;
   endproperty
   a_slot_len: assert property (p_slot_len) else $error("slot not eight bits");
   property p_dly_len;
      $fell(delayed_strobe_out) && hi_cnt_r < 8'd200 |-> hi_cnt_r inside {[8'd98:8'd102]};
   endproperty
   a_dly_len: assert property (p_dly_len) else $error("delayed strobe not eight bits");
   property p_fp_len;
      $rose(delayed_strobe_out) && lo_cnt_r < 8'd50 |-> lo_cnt_r inside {[8'd11:8'd14]};
   endproperty
   a_fp_len: assert property (p_fp_len) else $error("delayed pulse not one bit");
   property p_mp_oe;
      mp_cs_n [*6] |-> mp_data1_oe_n;
   endproperty
   a_mp_oe: assert property (p_mp_oe) else $error("data1 driven while deselected");
endmodule
bind cdp_port cdp_port_asserts u_chk (.clk, .rst, .address, .read, .write, .readdata,
   .waitrequest, .bit_clk, .chan_dout, .chan_dout_oe_n, .delayed_strobe_out, .mp_cs_n,
   .mp_data1_oe_n, .law_pin_i, .law_pin_o, .a_law_sel);

// ---- verif/cdp_l1_model.sv ----
// layer 1 transceiver model: bit clock, strobe and channel data
`timescale 1ns/100ps
module cdp_l1_model (
   // link pins
   output logic      bit_clk,
   output logic      slot_strobe,
   output logic      chan_din,
   // device outputs
   input  wire logic chan_dout,
   input  wire logic chan_dout_oe_n,
   input  wire logic delayed_strobe_out
);
   initial begin
      bit_clk = 1'b0;
      slot_strobe = 1'b0;
      chan_din = 1'b0;
   end
   // clock stands still between frames; din toggles outside the strobed slot, and through the whole frame in frame-pulse mode
   task automatic frame(input logic fbm, input logic [7:0] tx,
                        output logic [7:0] rx, output int bad);
      int lo;
      int p;
      bad = 0;
      lo = 0;
      p = 0;
      rx = 8'h00;
      for (int k = 0; k < 40; k++) begin
         slot_strobe = fbm ? (k != 0) : (k >= 1 && k <= 8);
         #62.5 bit_clk = 1'b1;
         #5 chan_din = (!fbm && k >= 1 && k <= 8) ? tx[8-k] : ~chan_din;
         #57.5 bit_clk = 1'b0;
         if (!fbm && k >= 1 && k <= 8) begin
            rx = {rx[6:0], chan_dout};
            if (chan_dout_oe_n !== 1'b0) bad++;
         end else if (!fbm && chan_dout_oe_n !== 1'b1) bad++;
         if (fbm) begin
            if (delayed_strobe_out !== 1'b1) begin
               lo++;
               p = k;
            end
         end else if ((k >= 2 && k <= 8 || k >= 19) && delayed_strobe_out !== 1'b0) bad++;
         else if (k >= 10 && k <= 15 && delayed_strobe_out !== 1'b1) bad++;
      end
      if (fbm && (lo != 1 || p < 32 || p > 33)) bad++;
   endtask
endmodule

// ---- verif/cdp_port_test.sv ----
// self-checking bench for the codec digital port
`timescale 1ns/100ps
module cdp_port_test;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  address = 5'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest, irq, power_on_clear_n = 1'b1;
   logic        bit_clk, slot_strobe, chan_din, chan_dout, chan_dout_oe_n, delayed_strobe_out;
   logic        mp_cs_n = 1'b1, mp_sclk = 1'b0, mp_d1_drv = 1'b0, mp_data2 = 1'b0;
   logic        mp_data1_o, mp_data1_oe_n, law_drv = 1'b0, law_pin_o, law_pin_oe_n, a_law_sel;
   wire         mp_data1 = mp_data1_oe_n ? mp_d1_drv : mp_data1_o;
   wire         law_pin = law_pin_oe_n ? law_drv : law_pin_o;
   int          failures = 0;
   int          n_tests = 0;
   logic [31:0] exp_q[$];
   always #5 clk = ~clk;
   cdp_port DUT (.clk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest,
      .irq, .power_on_clear_n, .bit_clk, .slot_strobe, .chan_din, .chan_dout,
      .chan_dout_oe_n, .delayed_strobe_out, .mp_cs_n, .mp_sclk, .mp_data1_i(mp_data1),
      .mp_data1_o, .mp_data1_oe_n, .mp_data2, .law_pin_i(law_pin), .law_pin_o,
      .law_pin_oe_n, .a_law_sel);
   cdp_l1_model u_l1 (.bit_clk, .slot_strobe, .chan_din, .chan_dout, .chan_dout_oe_n,
      .delayed_strobe_out);
   task automatic finish_test;
      if (failures == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // read results are compared where they appear, oldest note first
   always @(posedge clk) if (read && waitrequest === 1'b0) check(readdata, exp_q.pop_front());
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clk);
         t++;
      end while (waitrequest !== 1'b0 && t < 50);
      if (t >= 50) failures++;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, e);
   endtask
   // the unused data line carries the inverse so a wrong pick shows
   // read bits are taken as the clock rises, long after the device moved data1
   task automatic mp(input logic split, input logic [15:0] b, output logic [7:0] q);
      q = 8'h00;
      @(posedge clk);
      mp_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         repeat (10) @(posedge clk);
         mp_sclk <= 1'b0;
         mp_data2 <= split ? b[i] : ~b[i];
         mp_d1_drv <= split ? ~b[i] : b[i];
         repeat (10) @(posedge clk);
         if (i < 8) q = {q[6:0], mp_data1};
         mp_sclk <= 1'b1;
      end
      repeat (10) @(posedge clk);
      mp_cs_n <= 1'b1;
      repeat (10) @(posedge clk);
   endtask
   initial begin
      #200us;
      failures++;
      finish_test();
   end
   initial begin
      logic [7:0] tx, rb, got;
      int bad;
      void'($urandom(32'h5f3c));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rd(5'h00, 32'h0);
      rd(5'h14, 32'h0);
      rd(5'h1c, 32'h0);
      for (int i = 0; i < 4; i++) begin
         law_drv <= i[0];
         bus(1'b1, 5'h00, {31'h0, i[1]});
         repeat (8) @(posedge clk);
         check(32'(a_law_sel), 32'(i[0] | i[1]));
      end
      law_drv <= 1'b0;
      bus(1'b1, 5'h00, 32'h0);
      bus(1'b1, 5'h08, 32'h3);
      tx = 8'($urandom());
      rb = 8'($urandom());
      bus(1'b1, 5'h0c, {24'h0, tx});
      u_l1.frame(1'b0, rb, got, bad);
      @(posedge clk);
      check(32'(got), 32'(tx));
      check(32'(bad), 32'h0);
      rd(5'h10, {24'h0, rb});
      rd(5'h04, 32'h3);
      check(32'(irq), 32'h1);
      bus(1'b1, 5'h04, 32'h3);
      repeat (3) @(posedge clk);
      check(32'(irq), 32'h0);
      tx = 8'($urandom());
      mp(1'b0, {8'h03, tx}, got);
      rd(5'h0c, {24'h0, tx});
      rd(5'h04, 32'h8);
      bus(1'b1, 5'h00, 32'h8);
      rb = 8'($urandom());
      mp(1'b1, {8'h03, rb}, got);
      rd(5'h0c, {24'h0, rb});
      mp(1'b1, 16'h8300, got);
      check(32'(got), 32'(rb));
      bus(1'b1, 5'h04, 32'hf);
      bus(1'b1, 5'h00, 32'h6);
      u_l1.frame(1'b1, tx, got, bad);
      @(posedge clk);
      check(32'(bad), 32'h0);
      mp(1'b0, {8'h06, tx}, got);
      check(32'(law_pin_oe_n), 32'h0);
      rd(5'h18, {24'h0, tx});
      mp(1'b0, 16'h8600, got);
      check(32'(got), 32'(tx));
      bus(1'b1, 5'h04, 32'hf);
      repeat (3) @(posedge clk);
      check(32'(law_pin_oe_n), 32'h1);
      power_on_clear_n <= 1'b0;
      repeat (5) @(posedge clk);
      power_on_clear_n <= 1'b1;
      repeat (5) @(posedge clk);
      rd(5'h00, 32'h0);
      rd(5'h0c, 32'h0);
      rd(5'h18, 32'h0);
      repeat (3) @(posedge clk);
      finish_test();
   end
endmodule
